//--- key_wake_stop.sv
// halt entry and release logic with key wake inputs and avalon register slave
`timescale 1ns/100ps
`default_nettype none

module key_wake_stop
  import key_wake_pkg::*;
(
  // clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst,
  // avalon-mm slave
  input  wire av_req_t           i_av,
  output logic                   o_waitrequest,
  output logic [DATA_W-1:0]      o_readdata,
  // pins
  input  wire logic              i_port2_bit0_pin,
  input  wire logic [KEY_COUNT-1:0] i_port3_key_pins,
  // operating-mode controller
  input  wire logic              i_warmup_done,
  output logic                   o_halt,
  output logic                   o_release
);

  logic [7:0]        key_en_q;
  logic [7:0]        key_en_d;
  logic              release_method_select_q;
  logic              release_method_select_d;
  logic              wait_q;
  logic              wait_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  halt_state_t       state_q;
  halt_state_t       state_d;
  localparam int GW = $clog2(GUARD_CLKS + 1);
  logic [GW-1:0]     guard_q;
  logic [GW-1:0]     guard_d;
  logic              pin_prev_q;
  logic              halt_q;
  logic              halt_d;
  logic              rel_out_q;
  logic              rel_out_d;
  logic              key_hit;
  logic              release_now;
  logic              accept;
  logic              halt_cmd;

  function automatic logic hit_addr(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    hit_addr = (a == r);
  endfunction

  key_edge_detect #(
    .N (KEY_COUNT)
  ) u_keys (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_key     (i_port3_key_pins),
    .i_enable  (key_en_q[KEY_EN_LSB +: KEY_COUNT]),
    .o_hit     (key_hit)
  );

  // bus: one wait cycle, answer on the second edge of a request
  always_comb begin
    accept   = (i_av.read | i_av.write) & wait_q;
    wait_d   = ~accept;
    key_en_d = key_en_q;
    release_method_select_d   = release_method_select_q;
    halt_cmd = 1'b0;
    rdata_d  = '0;
    if (accept && i_av.write) begin
      if (hit_addr(i_av.address, ADDR_KEY_WAKE_ENABLE)) begin
        key_en_d = i_av.writedata[7:0];
      end
      if (hit_addr(i_av.address, ADDR_SYS_CTRL)) begin
        release_method_select_d   = i_av.writedata[SYS_RELEASE_METHOD_SELECT_BIT];
        halt_cmd = i_av.writedata[SYS_HALT_BIT];
      end
    end
    // the enable register is write-only and reads as zero
    if (accept && i_av.read) begin
      if (hit_addr(i_av.address, ADDR_SYS_CTRL)) begin
        rdata_d[SYS_RELEASE_METHOD_SELECT_BIT] = release_method_select_q;
      end
      if (hit_addr(i_av.address, ADDR_HALT_STATUS)) begin
        rdata_d[STAT_HALTED_BIT] = halt_q;
        rdata_d[STAT_GUARD_BIT]  = (state_q == ST_GUARD);
        rdata_d[STAT_WAKE_BIT]   = (state_q == ST_WAKE);
        rdata_d[STAT_RELEASE_METHOD_SELECT_BIT]   = release_method_select_q;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      wait_q   <= 1'b1;
      rdata_q  <= '0;
      key_en_q <= KEY_WAKE_ENABLE_RST;
      release_method_select_q   <= SYS_RELEASE_METHOD_SELECT_RST;
    end else begin
      wait_q   <= wait_d;
      rdata_q  <= rdata_d;
      key_en_q <= key_en_d;
      release_method_select_q   <= release_method_select_d;
    end
  end

  assign o_waitrequest = wait_q;
  assign o_readdata    = rdata_q;

  // release condition; the pin is the shared port 2 bit 0 input
  always_comb begin
    if (release_method_select_q) begin
      release_now = i_port2_bit0_pin | key_hit;
    end else begin
      // edge mode: keys cannot release, only a rising pin edge
      release_now = i_port2_bit0_pin & ~pin_prev_q;
    end
  end

  // halt sequencing; warm-up timing is left to the mode controller
  always_comb begin
    state_d   = state_q;
    guard_d   = guard_q;
    halt_d    = halt_q;
    rel_out_d = 1'b0;
    case (state_q)
      ST_RUN: begin
        if (halt_cmd) begin
          state_d = ST_GUARD;
          guard_d = GW'(GUARD_CLKS - 1);
          halt_d  = 1'b1;
        end
      end
      ST_GUARD: begin
        // early release requests are dropped, not remembered
        if (guard_q == '0) begin
          state_d = ST_HALT;
        end else begin
          guard_d = guard_q - GW'(1);
        end
      end
      ST_HALT: begin
        if (release_now) begin
          state_d   = ST_WAKE;
          rel_out_d = 1'b1;
        end
      end
      ST_WAKE: begin
        rel_out_d = 1'b1;
        if (i_warmup_done) begin
          state_d   = ST_RUN;
          halt_d    = 1'b0;
          rel_out_d = 1'b0;
        end
      end
      default: begin
        state_d = ST_RUN;
        halt_d  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_q    <= ST_RUN;
      guard_q    <= '0;
      halt_q     <= 1'b0;
      rel_out_q  <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      guard_q    <= guard_d;
      halt_q     <= halt_d;
      rel_out_q  <= rel_out_d;
      pin_prev_q <= i_port2_bit0_pin;
    end
  end

  assign o_halt    = halt_q;
  assign o_release = rel_out_q;

  // checks
  chk_guard_ignore: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_q == ST_RUN && halt_cmd) |=> (!o_release) [*8] ##1 (!o_release) [*4])
    else $error("release seen inside the guard window");

  chk_guard_length: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_q == ST_RUN && halt_cmd) |=> (state_q == ST_GUARD) [*8] ##1 (state_q == ST_GUARD) [*4]
    ##1 (state_q == ST_HALT))
    else $error("guard window length wrong");

  chk_halt_entry: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_q == ST_RUN && halt_cmd) |=> o_halt)
    else $error("halt command did not enter halt");

  chk_level_pin: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_q == ST_HALT && release_method_select_q && i_port2_bit0_pin) |=> o_release)
    else $error("high pin in level mode did not release");

  chk_edge_pin: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_q == ST_HALT && !release_method_select_q && $rose(i_port2_bit0_pin)) |=> o_release)
    else $error("rising pin in edge mode did not release");

  chk_edge_keys: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_q == ST_HALT && !release_method_select_q && !i_port2_bit0_pin) |=> !o_release)
    else $error("release in edge mode without a pin edge");

  chk_key_release: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_q == ST_HALT && release_method_select_q && $past(state_q) == ST_HALT && u_keys.primed_q
     && |(key_en_q[KEY_EN_LSB +: KEY_COUNT] & (i_port3_key_pins ^ $past(i_port3_key_pins))))
    |=> o_release)
    else $error("enabled key edge did not release");

  chk_disabled_key: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_q == ST_HALT && key_en_q[KEY_EN_LSB +: KEY_COUNT] == '0 && !i_port2_bit0_pin)
    |=> !o_release)
    else $error("release without any enabled source");

  chk_release_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (o_release && !i_warmup_done) |=> (o_release && o_halt))
    else $error("release dropped before warm-up done");

  chk_bus_answer: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (wait_q && (i_av.read || i_av.write)) |=> !o_waitrequest ##1 o_waitrequest)
    else $error("bus answer not one cycle after request");

  chk_wo_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (accept && i_av.read && hit_addr(i_av.address, ADDR_KEY_WAKE_ENABLE)) |=> o_readdata == '0)
    else $error("write-only register read back nonzero");

endmodule
`default_nettype wire

//--- key_wake_pkg.sv
// constants, register map and bus carrier types for the key wake-up block
package key_wake_pkg;

  // avalon slave geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_KEY_WAKE_ENABLE = 12'h031;
  localparam logic [ADDR_W-1:0] IDX_SYS_CTRL        = 12'h032;
  localparam logic [ADDR_W-1:0] IDX_HALT_STATUS     = 12'h033;
  localparam logic [ADDR_W-1:0] ADDR_KEY_WAKE_ENABLE = IDX_KEY_WAKE_ENABLE << 2;
  localparam logic [ADDR_W-1:0] ADDR_SYS_CTRL        = IDX_SYS_CTRL << 2;
  localparam logic [ADDR_W-1:0] ADDR_HALT_STATUS     = IDX_HALT_STATUS << 2;

  // key wake enable fields: bits 7..4 enable key inputs 3..0
  localparam int KEY_COUNT     = 4;
  localparam int KEY_EN_LSB    = 4;
  localparam logic [7:0] KEY_WAKE_ENABLE_RST = 8'h00;

  // system control fields
  localparam int SYS_HALT_BIT = 0;
  localparam int SYS_RELEASE_METHOD_SELECT_BIT = 1;
  localparam logic SYS_RELEASE_METHOD_SELECT_RST = 1'b0;

  // halt status fields
  localparam int STAT_HALTED_BIT = 0;
  localparam int STAT_GUARD_BIT  = 1;
  localparam int STAT_WAKE_BIT   = 2;
  localparam int STAT_RELEASE_METHOD_SELECT_BIT   = 3;

  // release is ignored for this many instruction cycles after halt entry
  localparam int GUARD_INSTR       = 3;
  localparam int INSTR_CYCLE_CLKS  = 4;
  localparam int GUARD_CLKS        = GUARD_INSTR * INSTR_CYCLE_CLKS;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [DATA_W-1:0] writedata;
  } av_req_t;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_GUARD = 2'b01,
    ST_HALT  = 2'b10,
    ST_WAKE  = 2'b11
  } halt_state_t;

endpackage

//--- key_edge_detect.sv
// per-key edge detection gated by the enable bits
`timescale 1ns/100ps
`default_nettype none
module key_edge_detect #(
  parameter int N = 4
) (
  // clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst,
  // keys and enables
  input  wire logic [N-1:0] i_key,
  input  wire logic [N-1:0] i_enable,
  // any enabled key changed level
  output logic              o_hit
);

  logic [N-1:0] prev_q;
  logic [N-1:0] prev_d;
  logic         primed_q;
  logic         primed_d;
  logic [N-1:0] hit;

  // the first sample after reset only primes history, so a key held high is no edge
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_key
      assign hit[g] = primed_q & i_enable[g] & (i_key[g] ^ prev_q[g]);
    end
  endgenerate

  always_comb begin
    prev_d   = i_key;
    primed_d = 1'b1;
    o_hit    = |hit;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      prev_q   <= '0;
      primed_q <= 1'b0;
    end else begin
      prev_q   <= prev_d;
      primed_q <= primed_d;
    end
  end

endmodule
`default_nettype wire

//--- key_switch_model.sv
// behavioural key and release-pin switches standing outside the wake-up block
`timescale 1ns/100ps
`default_nettype none
module key_switch_model (
  // clock
  input  wire logic       i_ref_clk,
  // commanded switch levels from the bench
  input  wire logic [3:0] i_keys_set,
  input  wire logic       i_pin_set,
  // pin levels seen by the device
  output logic [3:0]      o_keys,
  output logic            o_pin
);
  // contacts settle one cycle after the command; levels hold until the next command
  always_ff @(posedge i_ref_clk) begin
    o_keys <= i_keys_set;
    o_pin  <= i_pin_set;
  end
endmodule
`default_nettype wire

//--- testbench.sv
// self-checking bench for the key wake-up halt release block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import key_wake_pkg::*;
  logic              clk;
  logic              rst;
  av_req_t           av;
  logic              wait_req;
  logic [DATA_W-1:0] rdata;
  logic              warm;
  logic              halt;
  logic              rel;
  logic [3:0]        keys_set;
  logic              pin_set;
  logic [3:0]        keys;
  logic              pin;
  int                err_count;
  int                checks;
  logic [31:0]       q;
  int                k;
  int                n;
  logic [3:0]        en;
  logic              release_method_select;

  key_wake_stop u_key_wake_stop (
    .i_ref_clk        (clk),
    .i_rst            (rst),
    .i_av             (av),
    .o_waitrequest    (wait_req),
    .o_readdata       (rdata),
    .i_port2_bit0_pin (pin),
    .i_port3_key_pins (keys),
    .i_warmup_done    (warm),
    .o_halt           (halt),
    .o_release        (rel)
  );

  key_switch_model u_key_switch_model (
    .i_ref_clk  (clk),
    .i_keys_set (keys_set),
    .i_pin_set  (pin_set),
    .o_keys     (keys),
    .o_pin      (pin)
  );

  function automatic logic key_releases(input logic m, input logic [3:0] e, input int i);
    return m & e[i];
  endfunction

  function automatic logic [31:0] status_exp(input logic m);
    return 32'(m) << STAT_RELEASE_METHOD_SELECT_BIT;
  endfunction

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // request held until waitrequest is sampled low; the watchdog ends a hang
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    av <= '{address: a, read: !wr, write: wr, writedata: d};
    do begin
      @(posedge clk);
    end while (wait_req !== 1'b0);
    q = rdata;
    av <= '0;
  endtask

  task automatic release_halt();
    repeat (20) @(posedge clk);
    check("release_holds", 1'b1, rel);
    warm <= 1'b1;
    @(posedge clk);
    warm <= 1'b0;
    repeat (2) @(posedge clk);
    check("halt_clear", 1'b0, halt);
    check("release_clear", 1'b0, rel);
    pin_set <= 1'b0;
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (6000) @(posedge clk);
    err_count++;
    end_of_test();
  end

  initial begin
    err_count = 0;
    checks = 0;
    rst = 1'b1;
    av = '0;
    warm = 1'b0;
    keys_set = 4'h0;
    pin_set = 1'b0;
    void'($urandom(32'h7BF6F53B));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("waitrequest_idle", 1'b1, wait_req);
    check("halt_reset", 1'b0, halt);
    bus(1'b0, ADDR_KEY_WAKE_ENABLE, 32'h0);
    check("enable_write_only", 32'h0, q);
    bus(1'b0, 12'hFF0, 32'h0);
    check("unmapped_read", 32'h0, q);
    // a release level present during the guard must wait until the guard ends
    bus(1'b1, ADDR_SYS_CTRL, 32'h3);
    while (halt !== 1'b1) @(posedge clk);
    pin_set <= 1'b1;
    n = 0;
    while (rel !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    check("guard_window", 1'b1, n >= GUARD_CLKS && n <= GUARD_CLKS + 6);
    release_halt();
    for (int i = 0; i < 16; i++) begin
      k = i % 4;
      en = (i < 4) ? 4'(1 << k) : 4'($urandom);
      release_method_select = (i < 8) ? 1'b1 : 1'($urandom);
      bus(1'b1, ADDR_SYS_CTRL, {30'h0, release_method_select, 1'b0});
      bus(1'b0, ADDR_HALT_STATUS, 32'h0);
      check("status_release_method_select", status_exp(release_method_select), q);
      bus(1'b1, ADDR_KEY_WAKE_ENABLE, {24'h0, en, 4'($urandom)});
      bus(1'b1, ADDR_SYS_CTRL, {30'h0, release_method_select, 1'b1});
      while (halt !== 1'b1) @(posedge clk);
      repeat (GUARD_CLKS + 2) @(posedge clk);
      keys_set[k] <= ~keys_set[k];
      repeat (6) @(posedge clk);
      check("key_release", key_releases(release_method_select, en, k), rel);
      pin_set <= 1'b1;
      repeat (6) @(posedge clk);
      check("pin_release", 1'b1, rel);
      release_halt();
    end
    // a mid-run reset must clear the enables, so a key edge alone cannot release
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("halt_after_reset", 1'b0, halt);
    check("release_after_reset", 1'b0, rel);
    bus(1'b0, ADDR_HALT_STATUS, 32'h0);
    check("status_after_reset", 32'h0, q);
    bus(1'b1, ADDR_SYS_CTRL, 32'h3);
    repeat (GUARD_CLKS + 2) @(posedge clk);
    keys_set <= ~keys_set;
    repeat (6) @(posedge clk);
    check("enable_reset", 1'b0, rel);
    pin_set <= 1'b1;
    repeat (6) @(posedge clk);
    check("pin_after_reset", 1'b1, rel);
    release_halt();
    end_of_test();
  end
endmodule
`default_nettype wire
